/* File: rtl/prescaler_pkg.sv */
// constants shared by the timer prescaler and its register port
package prescaler_pkg;

   // ======================================================================
   // register offsets
   // ======================================================================
   localparam logic [7:0] GENERAL_TIMER_CONTROL_ADDR = 8'h43;
   localparam logic [7:0] TICK_SELECT_ADDR           = 8'h44;
   localparam logic [7:0] PRESCALE_COUNT_LO_ADDR     = 8'h45;
   localparam logic [7:0] PRESCALE_COUNT_HI_ADDR     = 8'h46;

   // ======================================================================
   // field positions
   // ======================================================================
   localparam int SYNC_HOLD_MODE_BIT         = 7;
   localparam int ASYNC_PRESCALER_RESET_BIT  = 1;
   localparam int SHARED_PRESCALER_RESET_BIT = 0;
   localparam int SELECT0_LSB                = 0;
   localparam int PIN0_LEVEL_BIT             = 3;
   localparam int SELECT1_LSB                = 4;
   localparam int PIN1_LEVEL_BIT             = 7;

   // ======================================================================
   // reset values
   // ======================================================================
   localparam logic [7:0] GENERAL_TIMER_CONTROL_RST = 8'h00;
   localparam logic [2:0] CLOCK_SELECT_RST          = 3'h0;
   localparam logic [9:0] PRESCALE_COUNT_RST        = 10'h000;

   // ======================================================================
   // widths and clock-select codes
   // ======================================================================
   localparam int PRESCALE_W = 10;
   localparam int NUM_TIMERS = 2;

   localparam logic [2:0] SEL_STOP     = 3'h0;
   localparam logic [2:0] SEL_DIRECT   = 3'h1;
   localparam logic [2:0] SEL_DIV8     = 3'h2;
   localparam logic [2:0] SEL_DIV64    = 3'h3;
   localparam logic [2:0] SEL_DIV256   = 3'h4;
   localparam logic [2:0] SEL_DIV1024  = 3'h5;
   localparam logic [2:0] SEL_EXT_FALL = 3'h6;
   localparam logic [2:0] SEL_EXT_RISE = 3'h7;

   // a tap fires when the low bits covered by divisor-1 are all ones
   localparam logic [9:0] DIV8_MASK    = 10'h007;
   localparam logic [9:0] DIV64_MASK   = 10'h03F;
   localparam logic [9:0] DIV256_MASK  = 10'h0FF;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;

endpackage

/* File: rtl/shared_timer_prescaler.sv */
// shared prescaler and tick selection for two timer/counters
//
// Functional notes
// - select 1 ticks every system clock
// - taps divide clock by 8, 64, 256, 1024
// - one free-running prescaler shared by both timers
// - each timer selects its source independently
// - first prescaled count within 1 to N+1 cycles
// - writing prescaler reset bit resets shared prescaler
// - reset bit self-clears unless hold mode active
// - hold mode keeps both reset bits asserted
// - clearing hold mode clears both reset bits
// - count pin sampled each cycle, latch then registers
// - one tick per rising (7) or falling (6) edge
// - counter updates 2.5 to 3.5 cycles after edge
// - external pin ticks bypass the prescaler
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps

module shared_timer_prescaler
   import prescaler_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       ext_count_pin0,
   input  wire logic       ext_count_pin1,
   output logic            timer_tick0,
   output logic            timer_tick1,
   output logic            async_prescaler_reset
);

   // ======================================================================
   // helper functions
   // ======================================================================
   function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
      tap_hit = ((cnt & mask) == mask);
   endfunction

   // tick for one timer from its own select field
   function automatic logic pick_tick(input logic [2:0] sel,
                                      input logic [9:0] cnt,
                                      input logic       run,
                                      input logic       rise,
                                      input logic       fall);
      case (sel)
         SEL_STOP:     pick_tick = 1'b0;
         SEL_DIRECT:   pick_tick = 1'b1;
         SEL_DIV8:     pick_tick = run && tap_hit(cnt, DIV8_MASK);
         SEL_DIV64:    pick_tick = run && tap_hit(cnt, DIV64_MASK);
         SEL_DIV256:   pick_tick = run && tap_hit(cnt, DIV256_MASK);
         SEL_DIV1024:  pick_tick = run && tap_hit(cnt, DIV1024_MASK);
         SEL_EXT_FALL: pick_tick = fall;
         SEL_EXT_RISE: pick_tick = rise;
         default:      pick_tick = 1'b0;
      endcase
   endfunction

   // ======================================================================
   // state
   // ======================================================================
   logic                  sync_hold_mode_q;
   logic                  shared_prescaler_reset_q;
   logic                  async_reset_q;
   logic [2:0]            clock_select_field0_q;
   logic [2:0]            clock_select_field1_q;
   logic [PRESCALE_W-1:0] prescale_q;
   logic [PRESCALE_W-1:0] prescale_d;
   logic                  pin0_sample_q;
   logic                  pin1_sample_q;
   logic                  pin0_sync_q;
   logic                  pin1_sync_q;
   logic                  pin0_prev_q;
   logic                  pin1_prev_q;
   logic                  pin0_old_q;
   logic                  pin1_old_q;
   logic [7:0]            rdata_d;
   logic                  ctrl_wr;
   logic                  sel_wr;
   logic                  prescale_run;

   assign ctrl_wr      = reg_wr && (reg_addr == GENERAL_TIMER_CONTROL_ADDR);
   assign sel_wr       = reg_wr && (reg_addr == TICK_SELECT_ADDR);
   assign prescale_run = !shared_prescaler_reset_q;

   // ======================================================================
   // control register: hold mode and prescaler resets
   // ======================================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_hold_mode_q         <= GENERAL_TIMER_CONTROL_RST[SYNC_HOLD_MODE_BIT];
         shared_prescaler_reset_q <= GENERAL_TIMER_CONTROL_RST[SHARED_PRESCALER_RESET_BIT];
         async_reset_q            <= GENERAL_TIMER_CONTROL_RST[ASYNC_PRESCALER_RESET_BIT];
      end
      else if (clk_en)
      begin
         if (ctrl_wr)
         begin
            sync_hold_mode_q <= reg_wdata[SYNC_HOLD_MODE_BIT];
            if (sync_hold_mode_q && !reg_wdata[SYNC_HOLD_MODE_BIT])
            begin
               // leaving hold mode releases both timers together
               shared_prescaler_reset_q <= 1'b0;
               async_reset_q            <= 1'b0;
            end
            else
            begin
               shared_prescaler_reset_q <= reg_wdata[SHARED_PRESCALER_RESET_BIT];
               async_reset_q            <= reg_wdata[ASYNC_PRESCALER_RESET_BIT];
            end
         end
         else if (!sync_hold_mode_q)
         begin
            shared_prescaler_reset_q <= 1'b0;
            async_reset_q            <= 1'b0;
         end
      end
   end

   assign async_prescaler_reset = async_reset_q;

   // ======================================================================
   // clock-select fields, one per timer
   // ======================================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clock_select_field0_q <= CLOCK_SELECT_RST;
         clock_select_field1_q <= CLOCK_SELECT_RST;
      end
      else if (clk_en && sel_wr)
      begin
         clock_select_field0_q <= reg_wdata[SELECT0_LSB +: 3];
         clock_select_field1_q <= reg_wdata[SELECT1_LSB +: 3];
      end
   end

   // ======================================================================
   // shared free-running prescaler
   // ======================================================================
   always_comb
   begin
      if (shared_prescaler_reset_q)
         prescale_d = PRESCALE_COUNT_RST;
      else
         prescale_d = prescale_q + 10'h001;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prescale_q <= PRESCALE_COUNT_RST;
      else if (clk_en)
         prescale_q <= prescale_d;
   end

   // ======================================================================
   // external pin sampling and edge detection
   // ======================================================================
   // capture at the falling edge stands in for a latch open while clk is high
   always_ff @(negedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin0_sample_q <= 1'b0;
         pin1_sample_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pin0_sample_q <= ext_count_pin0;
         pin1_sample_q <= ext_count_pin1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin0_sync_q <= 1'b0;
         pin1_sync_q <= 1'b0;
         pin0_prev_q <= 1'b0;
         pin1_prev_q <= 1'b0;
         pin0_old_q  <= 1'b0;
         pin1_old_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         pin0_sync_q <= pin0_sample_q;
         pin1_sync_q <= pin1_sample_q;
         pin0_prev_q <= pin0_sync_q;
         pin1_prev_q <= pin1_sync_q;
         pin0_old_q  <= pin0_prev_q;
         pin1_old_q  <= pin1_prev_q;
      end
   end

   // ======================================================================
   // tick outputs
   // ======================================================================
   // edge seen between the two late stages: pin to counter in 2.5 to 3.5 cycles
   assign timer_tick0 = clk_en && pick_tick(clock_select_field0_q, prescale_q, prescale_run,
                                            pin0_prev_q && !pin0_old_q,
                                            !pin0_prev_q && pin0_old_q);
   assign timer_tick1 = clk_en && pick_tick(clock_select_field1_q, prescale_q, prescale_run,
                                            pin1_prev_q && !pin1_old_q,
                                            !pin1_prev_q && pin1_old_q);

   // ======================================================================
   // register read port
   // ======================================================================
   always_comb
   begin
      rdata_d = 8'h00;
      case (reg_addr)
         GENERAL_TIMER_CONTROL_ADDR:
         begin
            rdata_d[SYNC_HOLD_MODE_BIT]         = sync_hold_mode_q;
            rdata_d[ASYNC_PRESCALER_RESET_BIT]  = async_reset_q;
            rdata_d[SHARED_PRESCALER_RESET_BIT] = shared_prescaler_reset_q;
         end
         TICK_SELECT_ADDR:
         begin
            rdata_d[SELECT0_LSB +: 3] = clock_select_field0_q;
            rdata_d[PIN0_LEVEL_BIT]   = pin0_sync_q;
            rdata_d[SELECT1_LSB +: 3] = clock_select_field1_q;
            rdata_d[PIN1_LEVEL_BIT]   = pin1_sync_q;
         end
         PRESCALE_COUNT_LO_ADDR: rdata_d = prescale_q[7:0];
         PRESCALE_COUNT_HI_ADDR: rdata_d = {6'h00, prescale_q[9:8]};
         default:                rdata_d = 8'h00;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (clk_en && reg_rd)
         reg_rdata <= rdata_d;
      else if (clk_en)
         reg_rdata <= 8'h00;
   end

   // ======================================================================
   // assertions
   // ======================================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_direct_tick_rate: assert property (
      clk_en && clock_select_field0_q == SEL_DIRECT |-> timer_tick0)
      else $error("direct select did not tick");

   a_div8_tap_phase: assert property (
      clk_en && clock_select_field1_q == SEL_DIV8 && timer_tick1
      |-> prescale_q[2:0] == 3'h7 && !shared_prescaler_reset_q)
      else $error("divide-by-8 tick at wrong phase");

   a_prescale_free_run: assert property (
      clk_en && !shared_prescaler_reset_q |=> prescale_q == $past(prescale_q) + 10'h001)
      else $error("prescaler did not advance");

   a_prescale_reset: assert property (
      clk_en && shared_prescaler_reset_q |=> prescale_q == 10'h000)
      else $error("prescaler not reset");

   a_reset_self_clear: assert property (
      clk_en && shared_prescaler_reset_q && !sync_hold_mode_q && !ctrl_wr
      |=> !shared_prescaler_reset_q)
      else $error("prescaler reset bit did not clear");

   a_hold_keeps_reset: assert property (
      clk_en && sync_hold_mode_q && async_reset_q && !ctrl_wr |=> async_reset_q)
      else $error("held reset bit dropped");

   a_hold_release: assert property (
      clk_en && ctrl_wr && sync_hold_mode_q && !reg_wdata[SYNC_HOLD_MODE_BIT]
      |=> !shared_prescaler_reset_q && !async_reset_q && !sync_hold_mode_q)
      else $error("leaving hold mode did not clear resets");

   a_fall_edge_tick: assert property (
      clk_en && clock_select_field1_q == SEL_EXT_FALL
      |-> timer_tick1 == (!pin1_prev_q && pin1_old_q))
      else $error("falling edge tick mismatch");

   a_single_edge_tick: assert property (
      clk_en && clock_select_field0_q == SEL_EXT_RISE && timer_tick0
      |=> !timer_tick0 || clock_select_field0_q != SEL_EXT_RISE)
      else $error("one pin edge gave two ticks");

   a_ext_edge_delay: assert property (
      (clk_en && $past(clk_en) && clock_select_field0_q == SEL_EXT_RISE
       && $rose(ext_count_pin0)) ##1 clk_en
      ##1 (clk_en && clock_select_field0_q == SEL_EXT_RISE) |-> timer_tick0)
      else $error("external edge tick late");

   a_ext_fall_bypass: assert property (
      (clk_en && $past(clk_en) && clock_select_field1_q == SEL_EXT_FALL
       && $fell(ext_count_pin1)) ##1 clk_en
      ##1 (clk_en && clock_select_field1_q == SEL_EXT_FALL) |-> timer_tick1)
      else $error("falling pin edge not passed straight through");

   a_pin_sample_delay: assert property (
      $past(clk_en) |-> pin0_sync_q == $past(ext_count_pin0))
      else $error("count pin not sampled each cycle");

   a_first_tap_count: assert property (
      clk_en && sel_wr && reg_wdata[SELECT0_LSB +: 3] == SEL_DIV8 && !shared_prescaler_reset_q
      |-> ##[1:9] (timer_tick0 || !clk_en || shared_prescaler_reset_q
                   || clock_select_field0_q != SEL_DIV8))
      else $error("first divided tick too late");

   a_select_independent: assert property (
      clk_en && sel_wr |=> clock_select_field0_q == $past(reg_wdata[SELECT0_LSB +: 3])
                          && clock_select_field1_q == $past(reg_wdata[SELECT1_LSB +: 3]))
      else $error("select fields not taken separately");

   a_hold_keeps_shared: assert property (
      clk_en && sync_hold_mode_q && shared_prescaler_reset_q && !ctrl_wr
      |=> shared_prescaler_reset_q)
      else $error("held prescaler reset dropped");

   a_stop_no_tick: assert property (
      clock_select_field1_q == SEL_STOP |-> !timer_tick1)
      else $error("stopped timer ticked");

   a_enable_gates_ticks: assert property (
      !clk_en |-> !timer_tick0 && !timer_tick1)
      else $error("tick while clock enable low");

   c_div1024_tick: cover property (
      clock_select_field0_q == SEL_DIV1024 && timer_tick0);
   c_hold_release: cover property (
      ctrl_wr && sync_hold_mode_q && !reg_wdata[SYNC_HOLD_MODE_BIT]);
   c_rise_tick: cover property (
      clock_select_field0_q == SEL_EXT_RISE && timer_tick0);
   c_fall_tick: cover property (
      clock_select_field1_q == SEL_EXT_FALL && timer_tick1);
   c_div8_start: cover property (
      sel_wr && reg_wdata[SELECT0_LSB +: 3] == SEL_DIV8);

endmodule

/* File: sim/ext_count_model.sv */
// behavioural external count source and timer counter for one timer input
`timescale 1ns/100ps

module ext_count_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [3:0] half,
   input  wire logic       tick,
   output logic            pin,
   output int              rises,
   output int              falls,
   output int              ticks,
   output logic            lat_bad
);
   int cnt;
   int age;

   // ======================================================================
   // pin source: toggles every half cycles, stands still while stopped
   // ======================================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin   <= 1'b0;
         cnt   <= 0;
         age   <= 0;
         rises <= 0;
         falls <= 0;
      end
      else if (run && cnt + 1 >= half)
      begin
         pin   <= !pin;
         cnt   <= 0;
         age   <= 0;
         rises <= rises + int'(!pin);
         falls <= falls + int'(pin);
      end
      else
      begin
         cnt <= run ? cnt + 1 : 0;
         age <= age + 1;
      end
   end

   // ======================================================================
   // timer counter: counts ticks and flags late or early ones
   // ======================================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ticks   <= 0;
         lat_bad <= 1'b0;
      end
      else if (tick === 1'b1)
      begin
         ticks <= ticks + 1;
         if (age != 2)
            lat_bad <= 1'b1;
      end
   end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the shared timer prescaler
`timescale 1ns/100ps

module tb_top
   import prescaler_pkg::*;
;
   logic       clk, rst_n, clk_en, reg_wr, reg_rd, m_rst_n, run;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, e;
   logic [3:0] half;
   logic       pin0, pin1, tick0, tick1, aps, b0, b1;
   int         r0, f0, k0, r1, f1, k1, c0, c1, p, n, o, tg;
   int         fails, checks_done;
   int         dv[4] = '{8, 64, 256, 1024};

   shared_timer_prescaler u_shared_timer_prescaler (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_count_pin0(pin0), .ext_count_pin1(pin1),
      .timer_tick0(tick0), .timer_tick1(tick1), .async_prescaler_reset(aps));
   ext_count_model u_ext_count_model0 (.clk(clk), .rst_n(m_rst_n), .run(run), .half(half),
      .tick(tick0), .pin(pin0), .rises(r0), .falls(f0), .ticks(k0), .lat_bad(b0));
   ext_count_model u_ext_count_model1 (.clk(clk), .rst_n(m_rst_n), .run(run), .half(half),
      .tick(tick1), .pin(pin1), .rises(r1), .falls(f1), .ticks(k1), .lat_bad(b1));

   always #10 clk = ~clk;

   // ======================================================================
   // bus, compare and measurement tasks
   // ======================================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask

   function automatic logic tk(input int w);
      return w != 0 ? tick1 : tick0;
   endfunction

   task automatic count(input int len, output int a, output int b);
      a = 0;
      b = 0;
      repeat (len)
      begin
         @(negedge clk);
         a += int'(tick0 === 1'b1);
         b += int'(tick1 === 1'b1);
      end
   endtask

   task automatic period(input int w, output int q);
      q = 0;
      @(negedge clk);
      while (tk(w) !== 1'b1 && q < 3000)
      begin
         @(negedge clk);
         q++;
      end
      @(negedge clk);
      q = 1;
      while (tk(w) !== 1'b1 && q < 3000)
      begin
         @(negedge clk);
         q++;
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ======================================================================
   // watchdog
   // ======================================================================
   initial
   begin
      repeat (60000) @(posedge clk);
      fails++;
      print_verdict();
   end

   // ======================================================================
   // main sequence
   // ======================================================================
   initial
   begin
      clk = 0; rst_n = 0; clk_en = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
      m_rst_n = 0; run = 0; half = 4'h4; fails = 0; checks_done = 0;
      void'($urandom(32'h5ba5));
      repeat (4) @(posedge clk);
      rst_n   <= 1'b1;
      m_rst_n <= 1'b1;
      rd(GENERAL_TIMER_CONTROL_ADDR, d);
      check(d, GENERAL_TIMER_CONTROL_RST);
      wr(8'h50, 8'hFF);
      rd(8'h50, d);
      check(d, 0);
      rd(TICK_SELECT_ADDR, d);
      check(d, 0);
      $display("test registers done");
      wr(TICK_SELECT_ADDR, 8'h01);
      count(16, c0, c1);
      check(c0, 16);
      check(c1, 0);
      @(posedge clk) clk_en <= 1'b0;
      @(negedge clk) check(tick0, 0);
      @(posedge clk) clk_en <= 1'b1;
      wr(TICK_SELECT_ADDR, 8'h00);
      rd(PRESCALE_COUNT_LO_ADDR, d);
      repeat (20) @(posedge clk);
      rd(PRESCALE_COUNT_LO_ADDR, e);
      check(8'(e - d), 22);
      $display("test direct and free run done");
      for (int i = 0; i < 4; i++)
      begin
         o = 2 + int'($urandom % 4);
         wr(TICK_SELECT_ADDR, {1'b0, 3'(o), 1'b0, 3'(i + 2)});
         period(0, p);
         check(p, dv[i]);
         period(1, p);
         check(p, dv[o - 2]);
      end
      $display("test taps done");
      wr(TICK_SELECT_ADDR, 8'h22);
      wr(GENERAL_TIMER_CONTROL_ADDR, 8'h83);
      rd(GENERAL_TIMER_CONTROL_ADDR, d);
      check(d, 8'h83);
      check(aps, 1);
      rd(PRESCALE_COUNT_LO_ADDR, d);
      check(d, 0);
      count(40, c0, c1);
      check(c0 + c1, 0);
      wr(GENERAL_TIMER_CONTROL_ADDR, 8'h00);
      n = 0;
      while (tick0 !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      check(n >= 1 && n <= 9, 1);
      check(tick1, 1);
      rd(GENERAL_TIMER_CONTROL_ADDR, d);
      check(d, 0);
      wr(GENERAL_TIMER_CONTROL_ADDR, 8'h03);
      @(negedge clk);
      check(aps, 1);
      rd(PRESCALE_COUNT_LO_ADDR, d);
      check(d, 0);
      rd(GENERAL_TIMER_CONTROL_ADDR, d);
      check(d, 0);
      check(aps, 0);
      $display("test hold and reset done");
      wr(TICK_SELECT_ADDR, 8'h00);
      @(posedge clk) m_rst_n <= 1'b0;
      @(posedge clk) m_rst_n <= 1'b1;
      wr(TICK_SELECT_ADDR, 8'h67);
      @(posedge clk);
      half <= 4'(4 + $urandom % 4);
      @(posedge clk) run <= 1'b1;
      repeat (200) @(posedge clk);
      run <= 1'b0;
      repeat (8) @(posedge clk);
      tg = 200 / int'(half);
      check(r0, (tg + 1) / 2);
      check(k0, (tg + 1) / 2);
      check(k1, tg / 2);
      check({b0, b1}, 0);
      rd(TICK_SELECT_ADDR, d);
      check(d, {pin1, 3'h6, pin0, 3'h7});
      $display("test external pin done");
      print_verdict();
   end
endmodule
